// ### sfm_pkg.sv
// package: command codes, id layout, status layout and timing of the memory slave
package sfm_pkg;

    // ------------------------------------------------------------
    // array and command codes
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int MEM_WORDS = 32768;
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_MEM_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_IDENTITY_READ = 8'h9F;

    // ------------------------------------------------------------
    // write protection
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 15'h6000;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 15'h4000;
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;

    // ------------------------------------------------------------
    // status byte and identity layout
    // ------------------------------------------------------------
    localparam int STAT_WPEN_BIT = 7;
    localparam int STAT_BP_HI_BIT = 3;
    localparam int STAT_BP_LO_BIT = 2;
    localparam int STAT_WEL_BIT = 1;
    localparam logic STAT_RESET_BIT = 1'b0;
    localparam int ID_BYTES = 9;
    localparam int ID_CONT_BYTES = 6;
    localparam int ID_FAM_LSB = 13;
    localparam int ID_DENS_LSB = 8;
    localparam int ID_SUB_LSB = 6;
    localparam int ID_REV_LSB = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_PERIOD_PS = 4000;
    localparam int WAKE_RECOVERY_NS = 400;
    localparam int WAKE_CYC_DEF = (WAKE_RECOVERY_NS * 1000) / CORE_PERIOD_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR_HI, PH_ADDR_LO, PH_DUMMY, PH_DATA, PH_IGNORE
    } sfm_phase_t;

    typedef enum logic [2:0] {
        FK_NONE, FK_SET, FK_CLEAR, FK_STATUS_WRITE, FK_WRITE, FK_SLEEP, FK_OTHER
    } sfm_kind_t;

    typedef enum logic [1:0] {PW_AWAKE, PW_ASLEEP, PW_WAKING} sfm_power_t;

    typedef struct packed {
        logic wpen;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_latch_flag;
    } sfm_status_t;

    typedef struct packed {
        sfm_kind_t kind;
        logic stw_done;
        logic [7:0] stw_byte;
    } sfm_frame_t;

endpackage : sfm_pkg

// ### sfm_spi_fram.sv
// serial peripheral slave for a 32K x 8 nonvolatile byte memory
// Summary of operation
// - write command, two address bytes, then data to successive addresses
// - top bit of the two address bytes is ignored, fifteen bits used
// - address counter advances per data byte and wraps top to zero
// - every data byte moves most significant bit first
// - select rising ends a write; no further bytes taken
// - burst write stops advancing and discards bytes at protected address
// - byte stored when its eighth bit arrives, partial bytes dropped
// - unlimited back-to-back write bytes, never busy
// - read sends data after command and address, serial input ignored
// - select rising ends a read and floats the output at once
// - fast read has one dummy byte of eight clocks before data
// - fast read streams, ignores input, floats on select rising
// - pause pin low with clock low freezes the transfer
// - pause pin high with clock low resumes; clock may toggle, select rising ends the frame
// - sleep entered only after sleep byte and a select rising edge
// - asleep: clock and input ignored, output floating, select watched
// - select falling wakes; output floats and commands ignored during recovery
// - identity read returns six continuation, one maker, two product bytes
// - product id: family 15-13, density 12-8, sub 7-6, rev 5-3, rsvd 2-0
// - command bytes: latch set 06, memory write 02, memory read 03
// - write latch set by latch-set command; only it allows writes
// - write latch clears at select rising after clear, status or memory write
// - two protect bits select none, upper quarter, upper half, whole array
`timescale 1ns/1ps
`default_nettype none
module sfm_spi_fram
    import sfm_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYC_DEF,
    parameter logic [7:0] ID_CONT = 8'h5A,   // arbitrary value
    parameter logic [7:0] ID_MAKER = 8'h3C,  // arbitrary value
    parameter logic [2:0] ID_FAMILY = 3'h2,  // arbitrary value
    parameter logic [4:0] ID_DENSITY = 5'h04, // arbitrary value
    parameter logic [1:0] ID_SUB = 2'h1,     // arbitrary value
    parameter logic [2:0] ID_REV = 3'h2      // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sck_clk,
    input wire logic cs_n,
    input wire logic si_i,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_o,
    output logic so_oe,
    output var sfm_status_t status_o,
    output logic asleep_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (WAKE_CYC < 1) begin : g_bad_wake
        $error("wake recovery count must be at least one cycle");
    end

    localparam int TMR_W = $clog2(WAKE_CYC + 1);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sfm_phase_t phase_q;
    logic [2:0] bit_q;
    logic [7:0] cmd_q;
    logic [7:0] rx_q;
    logic [7:0] rx_next;
    logic byte_end;
    logic [ADDR_W-1:0] addr_q;
    logic [3:0] id_idx_q;
    logic [7:0] tx_q;
    logic [7:0] rd_byte;
    logic [7:0] mem [0:MEM_WORDS-1];
    sfm_frame_t frame_q;
    logic [4:0] lk_sync;
    sfm_status_t stat_lk;
    logic busy_lk;
    logic is_mem_cmd;
    logic is_write;
    logic reading;
    logic prot_hit;
    logic [15:0] prod_id;
    logic [7:0] stat_byte;
    logic [1:0] core_sync;
    logic cs_s;
    logic wp_s;
    logic cs_prev_q;
    logic cs_rise;
    logic cs_fall;
    logic wel_q;
    logic wpen_q;
    logic [1:0] bp_q;
    sfm_power_t pwr_q;
    logic [TMR_W-1:0] tmr_q;

    // ------------------------------------------------------------
    // link side: crossings in from the core
    // ------------------------------------------------------------
    // status changes only between frames and power ends its wake a set count after select falls, so a level sync suffices
    sfm_sync2 #(.WIDTH(5)) u_lk_sync (
        .clk(sck_clk),
        .d({status_o, asleep_o}),
        .q(lk_sync)
    );

    assign stat_lk = sfm_status_t'(lk_sync[4:1]);
    assign busy_lk = lk_sync[0];

    // ------------------------------------------------------------
    // link side: decode helpers
    // ------------------------------------------------------------
    assign rx_next = {rx_q[6:0], si_i};
    assign byte_end = (bit_q == 3'h7);
    assign is_write = (cmd_q == CMD_MEM_WRITE);
    assign is_mem_cmd = is_write || (cmd_q == CMD_MEM_READ) || (cmd_q == CMD_FAST_READ);
    assign reading = (cmd_q == CMD_MEM_READ) || (cmd_q == CMD_FAST_READ)
        || (cmd_q == CMD_STATUS_READ) || (cmd_q == CMD_IDENTITY_READ);

    always_comb begin
        case ({stat_lk.block_protect_hi, stat_lk.block_protect_lo})
            PROT_NONE: prot_hit = 1'b0;
            PROT_QUARTER: prot_hit = (addr_q >= PROT_QUARTER_BASE);
            PROT_HALF: prot_hit = (addr_q >= PROT_HALF_BASE);
            default: prot_hit = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // link side: frame sequencer, sampled on rising clock
    // ------------------------------------------------------------
    // select high clears the frame at once, whatever the clock does
    always_ff @(posedge sck_clk or posedge cs_n) begin
        if (cs_n) begin
            phase_q <= PH_CMD;
            bit_q <= 3'h0;
            cmd_q <= 8'h00;
        end else if (hold_n) begin
            bit_q <= bit_q + 3'h1;
            if (byte_end) begin
                case (phase_q)
                    PH_CMD: begin
                        cmd_q <= rx_next;
                        if (busy_lk) begin
                            phase_q <= PH_IGNORE;
                        end else begin
                            case (rx_next)
                                CMD_MEM_READ, CMD_MEM_WRITE, CMD_FAST_READ: begin
                                    phase_q <= PH_ADDR_HI;
                                end
                                CMD_STATUS_READ, CMD_STATUS_WRITE, CMD_IDENTITY_READ: begin
                                    phase_q <= PH_DATA;
                                end
                                default: begin
                                    phase_q <= PH_IGNORE;
                                end
                            endcase
                        end
                    end
                    PH_ADDR_HI: begin
                        phase_q <= PH_ADDR_LO;
                    end
                    PH_ADDR_LO: begin
                        if (cmd_q == CMD_FAST_READ) begin
                            phase_q <= PH_DUMMY;
                        end else begin
                            phase_q <= PH_DATA;
                        end
                    end
                    PH_DUMMY: begin
                        phase_q <= PH_DATA;
                    end
                    default: begin
                        phase_q <= phase_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sck_clk) begin
        if (hold_n) begin
            rx_q <= rx_next;
        end
    end

    // ------------------------------------------------------------
    // link side: address counter and identity index
    // ------------------------------------------------------------
    always_ff @(posedge sck_clk) begin
        if (!cs_n && hold_n && byte_end) begin
            case (phase_q)
                PH_ADDR_HI: begin
                    addr_q[ADDR_W-1:8] <= rx_next[6:0];
                end
                PH_ADDR_LO: begin
                    addr_q[7:0] <= rx_next;
                end
                PH_DATA: begin
                    // a protected address holds the counter for the rest of a write frame; reads still advance
                    if (is_mem_cmd && !(is_write && prot_hit)) begin
                        addr_q <= addr_q + 15'h0001;
                    end
                end
                default: begin
                    addr_q <= addr_q;
                end
            endcase
        end
    end

    always_ff @(posedge sck_clk) begin
        if (!cs_n && hold_n && byte_end) begin
            if (phase_q == PH_CMD) begin
                id_idx_q <= 4'h0;
            end else if (phase_q == PH_DATA && id_idx_q != 4'(ID_BYTES)) begin
                id_idx_q <= id_idx_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // link side: array write
    // ------------------------------------------------------------
    // no page buffer: each byte lands on its eighth bit, so there is never a busy gap
    always_ff @(posedge sck_clk) begin
        if (!cs_n && hold_n && byte_end && phase_q == PH_DATA && is_write
            && stat_lk.write_latch_flag && !prot_hit) begin
            mem[addr_q] <= rx_next;
        end
    end

    // ------------------------------------------------------------
    // link side: frame report for the core
    // ------------------------------------------------------------
    // held after the frame: the clock stops, so the core reads a still word
    always_ff @(posedge sck_clk) begin
        if (!cs_n && hold_n) begin
            if (phase_q == PH_CMD && bit_q == 3'h0) begin
                frame_q.kind <= FK_NONE;
                frame_q.stw_done <= 1'b0;
            end
            if (phase_q == PH_CMD && byte_end && !busy_lk) begin
                case (rx_next)
                    CMD_LATCH_SET: frame_q.kind <= FK_SET;
                    CMD_LATCH_CLEAR: frame_q.kind <= FK_CLEAR;
                    CMD_STATUS_WRITE: frame_q.kind <= FK_STATUS_WRITE;
                    CMD_MEM_WRITE: frame_q.kind <= FK_WRITE;
                    CMD_SLEEP: frame_q.kind <= FK_SLEEP;
                    default: frame_q.kind <= FK_OTHER;
                endcase
            end
            if (phase_q == PH_DATA && byte_end && cmd_q == CMD_STATUS_WRITE
                && !frame_q.stw_done) begin
                frame_q.stw_done <= 1'b1;
                frame_q.stw_byte <= rx_next;
            end
        end
    end

    // ------------------------------------------------------------
    // link side: read data, changed on falling clock
    // ------------------------------------------------------------
    always_comb begin
        prod_id = 16'h0000;
        prod_id[ID_FAM_LSB +: 3] = ID_FAMILY;
        prod_id[ID_DENS_LSB +: 5] = ID_DENSITY;
        prod_id[ID_SUB_LSB +: 2] = ID_SUB;
        prod_id[ID_REV_LSB +: 3] = ID_REV;
    end

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[STAT_WPEN_BIT] = stat_lk.wpen;
        stat_byte[STAT_BP_HI_BIT] = stat_lk.block_protect_hi;
        stat_byte[STAT_BP_LO_BIT] = stat_lk.block_protect_lo;
        stat_byte[STAT_WEL_BIT] = stat_lk.write_latch_flag;
    end

    always_comb begin
        if (cmd_q == CMD_STATUS_READ) begin
            rd_byte = stat_byte;
        end else if (cmd_q == CMD_IDENTITY_READ) begin
            if (id_idx_q < 4'(ID_CONT_BYTES)) begin
                rd_byte = ID_CONT;
            end else if (id_idx_q == 4'(ID_CONT_BYTES)) begin
                rd_byte = ID_MAKER;
            end else if (id_idx_q == 4'(ID_CONT_BYTES + 1)) begin
                rd_byte = prod_id[15:8];
            end else if (id_idx_q == 4'(ID_CONT_BYTES + 2)) begin
                rd_byte = prod_id[7:0];
            end else begin
                rd_byte = 8'h00;
            end
        end else begin
            rd_byte = mem[addr_q];
        end
    end

    // serial input plays no part here, so it is ignored while data goes out
    always_ff @(negedge sck_clk or posedge cs_n) begin
        if (cs_n) begin
            tx_q <= 8'h00;
        end else if (hold_n) begin
            if (phase_q == PH_DATA && bit_q == 3'h0 && reading) begin
                tx_q <= rd_byte;
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign so_o = tx_q[7];
    // select and pause act on the enable directly, with no clock needed
    assign so_oe = !cs_n && hold_n && !busy_lk && reading
        && phase_q == PH_DATA;

    // ------------------------------------------------------------
    // core side: pin crossings and select edges
    // ------------------------------------------------------------
    sfm_sync2 #(.WIDTH(2)) u_core_sync (
        .clk(core_clk),
        .d({cs_n, wp_n}),
        .q(core_sync)
    );

    assign cs_s = core_sync[1];
    assign wp_s = core_sync[0];
    assign cs_rise = cs_s && !cs_prev_q;
    assign cs_fall = !cs_s && cs_prev_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_s;
        end
    end

    // ------------------------------------------------------------
    // core side: write latch and status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wel_q <= STAT_RESET_BIT;
        end else if (cs_rise && pwr_q == PW_AWAKE) begin
            case (frame_q.kind)
                FK_SET: wel_q <= 1'b1;
                FK_CLEAR, FK_STATUS_WRITE, FK_WRITE: wel_q <= 1'b0;
                default: wel_q <= wel_q;
            endcase
        end
    end

    // the status register is locked only when enable is set and the pin is low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wpen_q <= STAT_RESET_BIT;
            bp_q <= PROT_NONE;
        end else if (cs_rise && pwr_q == PW_AWAKE && frame_q.kind == FK_STATUS_WRITE
                     && frame_q.stw_done && wel_q && !(wpen_q && !wp_s)) begin
            wpen_q <= frame_q.stw_byte[STAT_WPEN_BIT];
            bp_q <= frame_q.stw_byte[STAT_BP_HI_BIT:STAT_BP_LO_BIT];
        end
    end

    assign status_o = '{wpen: wpen_q, block_protect_hi: bp_q[1],
                        block_protect_lo: bp_q[0], write_latch_flag: wel_q};

    // ------------------------------------------------------------
    // core side: sleep and wake-up recovery
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pwr_q <= PW_AWAKE;
        end else begin
            case (pwr_q)
                PW_AWAKE: begin
                    if (cs_rise && frame_q.kind == FK_SLEEP) begin
                        pwr_q <= PW_ASLEEP;
                    end
                end
                PW_ASLEEP: begin
                    if (cs_fall) begin
                        pwr_q <= PW_WAKING;
                    end
                end
                PW_WAKING: begin
                    if (tmr_q == TMR_W'(WAKE_CYC - 1)) begin
                        pwr_q <= PW_AWAKE;
                    end
                end
                default: begin
                    pwr_q <= PW_AWAKE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || pwr_q != PW_WAKING) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_q + TMR_W'(1);
        end
    end

    assign asleep_o = (pwr_q != PW_AWAKE);

endmodule : sfm_spi_fram
`default_nettype wire

// ### sfm_spi_fram_properties.sv
// checker: port-level properties of the memory slave
`timescale 1ns/1ps
`default_nettype none
module sfm_spi_fram_properties
    import sfm_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sck_clk,
    input wire logic cs_n,
    input wire logic si_i,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_o,
    input wire logic so_oe,
    input wire sfm_status_t status_o,
    input wire logic asleep_o
);
    // sync delay plus recovery count, with margin
    localparam int WAKE_MAX = WAKE_CYC + 12;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_float_deselect: assert property (cs_n |-> !so_oe)
        else $error("so driven while deselected");
    a_float_paused: assert property (!hold_n |-> !so_oe)
        else $error("so driven during pause");
    a_float_asleep: assert property (asleep_o |-> !so_oe)
        else $error("so driven while asleep");
    a_so_fall_only: assert property (
        (sck_clk && $past(sck_clk) && so_oe && $past(so_oe)) |-> $stable(so_o))
        else $error("so changed while sck high");
    a_latch_set_idle: assert property ($rose(status_o.write_latch_flag) |-> cs_n)
        else $error("latch set inside a frame");
    a_latch_clr_idle: assert property ($fell(status_o.write_latch_flag) |-> cs_n)
        else $error("latch cleared inside a frame");
    a_protect_idle: assert property (!$stable(status_o[3:1]) |-> cs_n)
        else $error("protect bits changed inside a frame");
    a_sleep_at_end: assert property ($rose(asleep_o) |-> cs_n)
        else $error("sleep entered before select rose");
    a_wake_not_early: assert property (($fell(cs_n) && asleep_o) |-> asleep_o[*3])
        else $error("woke before recovery");
    a_wake_bounded: assert property (($fell(cs_n) && asleep_o) |-> ##[1:WAKE_MAX] !asleep_o)
        else $error("wake recovery too long");
endmodule : sfm_spi_fram_properties
bind sfm_spi_fram sfm_spi_fram_properties #(.WAKE_CYC(WAKE_CYC)) sfm_spi_fram_properties_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sck_clk(sck_clk), .cs_n(cs_n), .si_i(si_i),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .status_o(status_o),
    .asleep_o(asleep_o)
);
`default_nettype wire

// ### sfm_spi_master.sv
// partner model: serial bus master, mode 0, clock stopped between frames
`timescale 1ns/1ps
`default_nettype none
module sfm_spi_master (
    output logic sck_clk,
    output logic cs_n,
    output logic si_i,
    output logic hold_n,
    input wire logic so_w
);
    initial begin
        sck_clk = 1'b0;
        cs_n = 1'b1;
        si_i = 1'b0;
        hold_n = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        si_i = b;
        #24 sck_clk = 1'b1;
        r = so_w;
        #24 sck_clk = 1'b0;
    endtask : bit_io
    // h: byte index paused mid-way; t: bits of a partial trailing byte
    task automatic frame(input logic [7:0] tx[$], input int h, input int t,
        output logic [7:0] rx[$]);
        logic [7:0] r;
        rx = {};
        // odd offsets keep link edges clear of core clock edges
        #1 cs_n = 1'b0;
        #30;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                if (k == h && i == 3) begin
                    // pause moves mid-way through clock low, never on an edge
                    #12 hold_n = 1'b0;
                    repeat (2) begin
                        #24 sck_clk = 1'b1;
                        #24 sck_clk = 1'b0;
                    end
                    #12 hold_n = 1'b1;
                    #12;
                end
                bit_io(tx[k][i], r[i]);
            end
            rx.push_back(r);
        end
        for (int i = 7; i > 7 - t; i--) bit_io(1'b1, r[i]);
        #24 cs_n = 1'b1;
        // released line must not hold its last level
        si_i = ~si_i;
        #101;
    endtask : frame
endmodule : sfm_spi_master
`default_nettype wire

// ### sfm_sync2.sv
// two flip-flop level synchroniser, width set by parameter
`timescale 1ns/1ps
`default_nettype none
module sfm_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule : sfm_sync2
`default_nettype wire

// ### tb_top.sv
// self-checking bench: memory slave driven by the master model
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sfm_pkg::*;
;
    localparam logic [71:0] ID_EXP = {{6{8'h5A}}, 8'h3C, 3'h2, 5'h04, 2'h1, 3'h2, 3'h0};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck_clk, cs_n, si_i, hold_n, so_o, so_oe, asleep_o;
    wire logic so_w;
    sfm_status_t status_o;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int pb[4] = '{MEM_WORDS, 32'h6000, 32'h4000, 0};
    logic [7:0] mem [int];
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    logic [7:0] d;
    assign so_w = so_oe ? so_o : 1'bz;
    always #2 core_clk = ~core_clk;
    sfm_spi_master sfm_spi_master_inst (.sck_clk(sck_clk), .cs_n(cs_n), .si_i(si_i),
        .hold_n(hold_n), .so_w(so_w));
    // identity values stay at their defaults, which ID_EXP mirrors
    sfm_spi_fram #(.WAKE_CYC(4)) sfm_spi_fram_inst (
        .core_clk(core_clk), .rst_n(rst_n), .sck_clk(sck_clk), .cs_n(cs_n), .si_i(si_i),
        .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .status_o(status_o),
        .asleep_o(asleep_o));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic fr(input int h, input int t);
        sfm_spi_master_inst.frame(tx, h, t, rx);
    endtask : fr
    // burst write; bytes at or past the protect base are dropped for the frame
    task automatic wr(input logic latch, input int a, input int n, input int t, input int prot);
        if (latch) begin
            tx = {CMD_LATCH_SET};
            fr(-1, 0);
            chk({7'h0, status_o.write_latch_flag}, 8'h01);
        end
        tx = {CMD_MEM_WRITE, 8'(a >> 8) | 8'h80, 8'(a)};
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            tx.push_back(d);
            if (a >= prot) prot = 0;
            if (latch && a < prot) mem[a] = d;
            a = (a + 1) % MEM_WORDS;
        end
        fr(-1, t);
        chk({7'h0, status_o.write_latch_flag}, 8'h00);
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input int a, input int n, input int h);
        tx = {cmd, 8'(a >> 8) | 8'h80, 8'(a)};
        if (cmd == CMD_FAST_READ) tx.push_back(8'($urandom));
        for (int k = 0; k < n; k++) tx.push_back(8'($urandom));
        fr(h, 0);
        for (int k = 0; k < n; k++) begin
            chk(rx[tx.size() - n + k], mem[(a + k) % MEM_WORDS]);
        end
    endtask : rd
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'hB0BC979C));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        wr(1'b1, 32'h7FFE, 5, 0, MEM_WORDS);
        wr(1'b0, 32'h7FFE, 3, 0, MEM_WORDS);
        wr(1'b1, 32'h0001, 1, 4, MEM_WORDS);
        rd(CMD_MEM_READ, 32'h7FFE, 5, -1);
        // pause inside the first data byte of a fast read
        rd(CMD_FAST_READ, 32'h7FFE, 5, 4);
        for (int p = 0; p < 4; p++) begin
            tx = {CMD_LATCH_SET};
            fr(-1, 0);
            tx = {CMD_STATUS_WRITE, 8'(p << 2)};
            fr(-1, 0);
            chk({4'h0, status_o}, 8'(p << 1));
            wr(1'b1, 32'h5FFE, 4, 0, pb[p]);
            rd(CMD_MEM_READ, 32'h5FFE, 4, -1);
        end
        // protect enable with the pin low locks the status byte
        tx = {CMD_LATCH_SET};
        fr(-1, 0);
        tx = {CMD_STATUS_WRITE, 8'h80};
        fr(-1, 0);
        @(posedge core_clk);
        wp_n <= 1'b0;
        tx = {CMD_LATCH_SET};
        fr(-1, 0);
        tx = {CMD_STATUS_WRITE, 8'h8C};
        fr(-1, 0);
        chk({4'h0, status_o}, 8'h08);
        tx = {CMD_LATCH_SET};
        fr(-1, 0);
        tx = {CMD_LATCH_CLEAR};
        fr(-1, 0);
        chk({4'h0, status_o}, 8'h08);
        tx = {CMD_STATUS_READ, 8'($urandom)};
        fr(-1, 0);
        chk(rx[1], 8'h80);
        @(posedge core_clk);
        wp_n <= 1'b1;
        tx = {CMD_IDENTITY_READ};
        repeat (10) tx.push_back(8'($urandom));
        fr(-1, 0);
        for (int k = 0; k < 10; k++) begin
            chk(rx[k + 1], k < 9 ? ID_EXP[8 * (8 - k) +: 8] : 8'h00);
        end
        tx = {CMD_SLEEP};
        fr(-1, 0);
        chk({7'h0, asleep_o}, 8'h01);
        // throwaway frame starts the wake, then the rest of recovery passes
        tx = {CMD_MEM_READ, 8'h00, 8'h00, 8'h00};
        fr(-1, 0);
        chk({7'h0, asleep_o}, 8'h00);
        rd(CMD_MEM_READ, 32'h7FFE, 5, -1);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
